/* File: verilog/tlc_pkg.sv */
// Constants, entry layout and helpers of the translation checker
// What this block does
// R1 - Shadow buffer searched first, unified on miss
// R2 - Instruction shadow miss adds four cycles
// R3 - Data shadow miss adds three cycles
// R4 - Data side wins simultaneous unified requests
// R5 - All entries of a buffer compared together
// R6 - Hit needs valid, tag match, process match
// R7 - Zero entry tag matches every process
// R8 - Process zero hits only zero-tag entries
// R9 - Software never loads duplicate matching entries
// R10 - Physical address from sized page and offset
// R11 - Software zeroes unused real page bits
// R12 - Access checked before attributes are applied
// R13 - Any failure but a dropped speculative op faults and clears relocation
// R14 - User access to zone 00 denied
// R15 - Store to read-only page denied unless overridden
// R16 - Store to custom-attribute page traps if enabled
// R17 - Fetch denied: guarded, zone 00, no execute
// R18 - Execute denial signalled at execute, not fetch
// R19 - Data miss faults except cache touch
// R20 - Fetch miss raises instruction miss
// R21 - Checks only while relocation is enabled
// R22 - Reads blocked only by user zone 00
// R23 - Size code quadruples page, drops two bits
// R24 - Zone selector picks two-bit override field
package tlc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PID = 8'h04;
  localparam logic [7:0] OFS_ZONE = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_ECMD = 8'h10;
  localparam logic [7:0] OFS_EHI = 8'h14;
  localparam logic [7:0] OFS_ELO = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  // Field positions
  localparam int CTRL_USER = 0;
  localparam int CTRL_IREL = 1;
  localparam int CTRL_DREL = 2;
  localparam int CFG_TRAP = 0;
  localparam int CMD_TID = 8;
  localparam int EHI_LSB = 4;
  localparam int STAT_IMISS = 0;
  localparam int STAT_DMISS = 1;
  localparam int STAT_DSTOR = 2;
  localparam int STAT_ISTOR = 3;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] PID_RST = 8'h00;
  localparam logic [31:0] ZONE_RST = 32'h00000000;
  localparam logic [31:0] ENTRY_RST = 32'h00000000;
  localparam logic [3:0] STAT_RST = 4'h0;
  // Lookup penalties in core cycles
  localparam logic [2:0] IMISS_CYCLES = 3'h4;
  localparam logic [2:0] DMISS_CYCLES = 3'h3;
  // Buffer depths and entry layout
  localparam int UNI_DEPTH = 16;
  localparam int SHADOW_DEPTH = 4;
  localparam int TAG_W = 22;
  localparam int HI_W = 36;
  localparam int LO_W = 32;
  localparam int HI_TAG = 14;
  localparam int HI_SIZE = 11;
  localparam int HI_VALID = 10;
  localparam int HI_ENDIAN = 9;
  localparam int HI_CUSTOM = 8;
  localparam int LO_RPN = 10;
  localparam int LO_EXEC = 9;
  localparam int LO_WR = 8;
  localparam int LO_ZONE_SELECTOR = 4;
  localparam int LO_WT = 3;
  localparam int LO_INH = 2;
  localparam int LO_GRD = 0;

  typedef enum logic [3:0] {K_LOAD, K_STORE, K_FLUSH, K_BSTORE, K_ZERO,
    K_IINVAL, K_DINVAL, K_CCINVAL, K_ICCINVAL, K_TOUCH, K_ALLOC} tlc_kind_t;
  typedef enum logic [1:0] {SIDE_IDLE, SIDE_WAIT, SIDE_UNI} tlc_side_t;

  // R23 each size step clears two more low tag bits
  function automatic logic [TAG_W-1:0] pageMask(input logic [2:0] size);
    pageMask = {TAG_W{1'b1}} << {size, 1'b0};
  endfunction

  // R10 page bits from entry, offset bits from address
  function automatic logic [31:0] physAddr(input logic [31:0] ea,
      input logic [LO_W-1:0] lo, input logic [2:0] size);
    logic [TAG_W-1:0] m;
    m = pageMask(size);
    physAddr = {(lo[LO_W-1:LO_RPN] & m) | (ea[31:10] & ~m), ea[9:0]};
  endfunction

  // R24 zone 0 sits in the two top bits
  function automatic logic [1:0] zoneOf(input logic [31:0] zone,
      input logic [3:0] sel);
    zoneOf = zone[5'd31 - {sel, 1'b0} -: 2];
  endfunction
endpackage

/* File: verilog/tlc_lookup_if.sv */
// Lookup port between the top and one translation buffer
interface tlc_lookup_if;
  import tlc_pkg::*;
  logic [TAG_W-1:0] effective_page_number;
  logic [7:0] process_identifier;
  logic hit;
  logic [HI_W-1:0] hi;
  logic [LO_W-1:0] lo;
  modport searcher (output effective_page_number, output process_identifier, input hit, input hi, input lo);
  modport buffer (input effective_page_number, input process_identifier, output hit, output hi, output lo);
endinterface

/* File: verilog/tlc_buffer.sv */
// Translation buffer: flop storage with a fully parallel search
module tlc_buffer import tlc_pkg::*; #(
  parameter int DEPTH = SHADOW_DEPTH
) (
  input wire logic clk,                        // Core clock
  input wire logic sys_rst,                    // Sync reset
  input wire logic wrEn,                       // Entry write strobe
  input wire logic [$clog2(DEPTH)-1:0] wrIdx,  // Entry index
  input wire logic [HI_W-1:0] wrHi,            // Tag half
  input wire logic [LO_W-1:0] wrLo,            // Data half
  input wire logic invalAll,                   // Drop every entry
  tlc_lookup_if.buffer lk                      // Search port
);
  logic [HI_W-1:0] hi_q [DEPTH];
  logic [LO_W-1:0] lo_q [DEPTH];
  logic [DEPTH-1:0] matchVec;

  // R5 one comparator per entry, all in the same cycle
  for (genvar k = 0; k < DEPTH; k++) begin : g_cmp
    wire [TAG_W-1:0] m = pageMask(hi_q[k][HI_SIZE +: 3]);
    wire tagEq = ((hi_q[k][HI_TAG +: TAG_W] ^ lk.effective_page_number) & m) == '0;
    // R7 zero tag skips the process compare
    // R8 process zero still needs an exact match
    wire pidEq = (hi_q[k][7:0] == 8'h00) || (hi_q[k][7:0] == lk.process_identifier);
    // R6 valid, tag and process must all agree
    assign matchVec[k] = hi_q[k][HI_VALID] && tagEq && pidEq;
  end

  // OR of matching entries; duplicates are a software fault (R9)
  always_comb begin
    lk.hi = '0;
    lk.lo = '0;
    for (int k = 0; k < DEPTH; k++) begin
      if (matchVec[k]) begin
        lk.hi = lk.hi | hi_q[k];
        lk.lo = lk.lo | lo_q[k];
      end
    end
  end
  assign lk.hit = |matchVec;

  // Storage; invalidate wins over a same-cycle fill
  always_ff @(posedge clk) begin
    for (int k = 0; k < DEPTH; k++) begin
      if (sys_rst || invalAll) begin
        hi_q[k] <= '0;
        lo_q[k] <= '0;
      end else if (wrEn && wrIdx == k[$clog2(DEPTH)-1:0]) begin
        hi_q[k] <= wrHi;
        lo_q[k] <= wrLo;
      end
    end
  end
endmodule

/* File: verilog/tlc_prot.sv */
// Access-protection decision for one translated access
module tlc_prot import tlc_pkg::*; (
  input wire logic userMode,           // Problem state
  input wire logic [LO_W-1:0] lo,      // Entry data half
  input wire logic customAttr,         // Entry custom attribute
  input wire logic trapEn,             // Custom attribute trap enable
  input wire logic [1:0] zoneField,    // Selected zone override
  input wire tlc_kind_t kind,          // Data access kind
  output logic fetchDeny,              // Fetch not permitted
  output logic dataDeny                // Data access not permitted
);
  // R14 zone 00 locks user mode out
  wire zoneNone = userMode && zoneField == 2'b00;
  // Override: 11 in user mode, 10 or 11 privileged
  wire zoneOvr = userMode ? zoneField == 2'b11 : zoneField[1];
  // R22 loads only meet the zone check
  wire zoneKind = kind inside {K_LOAD, K_STORE, K_FLUSH, K_BSTORE, K_ZERO,
    K_IINVAL, K_TOUCH, K_ALLOC};
  wire storeKind = kind inside {K_STORE, K_ZERO, K_DINVAL, K_CCINVAL,
    K_ALLOC};

  // R15 read-only page unless zone overrides
  wire roDeny = storeKind && !lo[LO_WR] && !zoneOvr;
  // R16 custom attribute trap on store-type in any mode
  wire customDeny = storeKind && customAttr && trapEn;
  assign dataDeny = (zoneNone && zoneKind) || roDeny || customDeny;

  // R17 guarded, zone 00 or no execute permission
  assign fetchDeny = lo[LO_GRD] || zoneNone || (!lo[LO_EXEC] && !zoneOvr);
endmodule

/* File: verilog/tlc_mmu.sv */
// Translation lookup and access check, with APB register port
//
// The APB slave port and the placing of the registers were decided locally.
module tlc_mmu import tlc_pkg::*; (
  input wire logic clk,                // Core clock
  input wire logic sys_rst,            // Sync reset, active high
  input wire logic psel,               // APB select
  input wire logic penable,            // APB access phase
  input wire logic pwrite,             // APB write
  input wire logic [7:0] paddr,        // APB byte address
  input wire logic [31:0] pwdata,      // APB write data
  output logic [31:0] prdata,          // APB read data
  output logic pready,                 // APB ready
  output logic pslverr,                // APB error
  input wire logic fetchReq,           // Fetch request, held
  input wire logic [31:0] fetchAddr,   // Fetch effective address
  output logic fetchDone,              // Fetch result pulse
  output logic [31:0] fetchPhys,       // Fetch physical address
  output logic [3:0] fetchAttr,        // Endian, wt, inhibit, guard
  output logic fetchMiss,              // Instruction miss pulse
  output logic fetchDeny,              // Fetch denied, tag only
  input wire logic execValid,          // Instruction executes
  input wire logic execDeny,           // Its fetch deny tag
  output logic instrStorageFault,      // Instruction storage pulse
  input wire logic dataReq,            // Data request, held
  input wire logic [31:0] dataAddr,    // Data effective address
  input wire tlc_kind_t dataKind,      // Data access kind
  output logic dataDone,               // Data result pulse
  output logic [31:0] dataPhys,        // Data physical address
  output logic [3:0] dataAttr,         // Endian, wt, inhibit, guard
  output logic dataMiss,               // Data miss pulse
  output logic dataStorageFault,       // Data storage pulse
  output logic dataNoop                // Speculative op dropped
);
  // Software-visible state
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [7:0] pid_q;
  logic [31:0] zone_q;
  logic trap_q;
  logic [31:0] ehi_q;
  logic [31:0] elo_q;
  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [31:0] prdata_q;

  // Lookup side state
  tlc_side_t iState_q;
  tlc_side_t iState_d;
  tlc_side_t dState_q;
  tlc_side_t dState_d;
  logic [2:0] iCnt_q;
  logic [2:0] iCnt_d;
  logic [2:0] dCnt_q;
  logic [2:0] dCnt_d;
  logic [1:0] iPtr_q;
  logic [1:0] dPtr_q;

  // Registered results
  logic fetchDone_q;
  logic [31:0] fetchPhys_q;
  logic [3:0] fetchAttr_q;
  logic fetchMiss_q;
  logic fetchDeny_q;
  logic isi_q;
  logic dataDone_q;
  logic [31:0] dataPhys_q;
  logic [3:0] dataAttr_q;
  logic dataMiss_q;
  logic dataFault_q;
  logic dataNoop_q;

  tlc_lookup_if iLk();
  tlc_lookup_if dLk();
  tlc_lookup_if uLk();

  // APB decode
  wire apbSetup = psel && !penable;
  wire apbWr = psel && penable && pwrite;
  wire mapped = paddr inside {OFS_CTRL, OFS_PID, OFS_ZONE, OFS_CFG,
    OFS_ECMD, OFS_EHI, OFS_ELO, OFS_STAT};
  wire wrCtrl = apbWr && paddr == OFS_CTRL;
  wire wrPid = apbWr && paddr == OFS_PID;
  wire wrZone = apbWr && paddr == OFS_ZONE;
  wire wrCfg = apbWr && paddr == OFS_CFG;
  wire wrEcmd = apbWr && paddr == OFS_ECMD;
  wire wrEhi = apbWr && paddr == OFS_EHI;
  wire wrElo = apbWr && paddr == OFS_ELO;
  wire wrStat = apbWr && paddr == OFS_STAT;

  // Read mux; command register reads as zero
  wire [31:0] rdMux =
    paddr == OFS_CTRL ? {29'h0, ctrl_q} :
    paddr == OFS_PID ? {24'h0, pid_q} :
    paddr == OFS_ZONE ? zone_q :
    paddr == OFS_CFG ? {31'h0, trap_q} :
    paddr == OFS_EHI ? ehi_q :
    paddr == OFS_ELO ? elo_q :
    paddr == OFS_STAT ? {28'h0, stat_q} : 32'h0;

  // Zero-wait slave; data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // Relocation and mode
  wire userMode = ctrl_q[CTRL_USER];
  wire iReloc = ctrl_q[CTRL_IREL];
  wire dReloc = ctrl_q[CTRL_DREL];

  // New requests are taken only while idle and not in the done cycle
  wire iTake = fetchReq && iState_q == SIDE_IDLE && !fetchDone_q;
  wire dTake = dataReq && dState_q == SIDE_IDLE && !dataDone_q;
  wire iUseUni = iState_q == SIDE_UNI;
  wire dUseUni = dState_q == SIDE_UNI;

  // R1 shadow search first; unified only after a shadow miss
  wire iUniReq = (iTake && iReloc && !iLk.hit) || iState_q == SIDE_WAIT;
  wire dUniReq = (dTake && dReloc && !dLk.hit) || dState_q == SIDE_WAIT;
  wire uniBusy = iUseUni || dUseUni;
  // R4 data side granted first on a tie
  wire dGrant = dUniReq && !uniBusy;
  wire iGrant = iUniReq && !uniBusy && !dUniReq;
  wire iFinish = iUseUni && iCnt_q == 3'h0;
  wire dFinish = dUseUni && dCnt_q == 3'h0;

  // Search ports; the unified buffer follows its owner
  assign iLk.effective_page_number = fetchAddr[31:10];
  assign iLk.process_identifier = pid_q;
  assign dLk.effective_page_number = dataAddr[31:10];
  assign dLk.process_identifier = pid_q;
  assign uLk.effective_page_number = iUseUni ? fetchAddr[31:10] : dataAddr[31:10];
  assign uLk.process_identifier = pid_q;

  // Selected entry for each side
  wire iHit = iUseUni ? uLk.hit : iLk.hit;
  wire [HI_W-1:0] iHi = iUseUni ? uLk.hi : iLk.hi;
  wire [LO_W-1:0] iLo = iUseUni ? uLk.lo : iLk.lo;
  wire dHit = dUseUni ? uLk.hit : dLk.hit;
  wire [HI_W-1:0] dHi = dUseUni ? uLk.hi : dLk.hi;
  wire [LO_W-1:0] dLo = dUseUni ? uLk.lo : dLk.lo;

  // R21 translation and checks only with relocation on
  wire iRelPath = iUseUni || (iTake && iReloc);
  wire dRelPath = dUseUni || (dTake && dReloc);
  wire iDone = (iTake && (!iReloc || iLk.hit)) || iFinish;
  wire dDone = (dTake && (!dReloc || dLk.hit)) || dFinish;

  logic iProtDeny;
  logic dProtDeny;
  wire dTouch = dataKind == K_TOUCH;
  wire dSpec = dTouch || dataKind == K_ALLOC;

  // R20 fetch miss after both buffers missed
  wire iMissEv = iFinish && !uLk.hit;
  // R19 data miss, except cache touch
  wire dMissEv = dFinish && !uLk.hit && !dTouch;
  // R18 fetch deny is a tag, faulted only at execute
  wire iDenyEv = iDone && iRelPath && iHit && iProtDeny;
  wire isiEv = execValid && execDeny;
  // R13 denied data access faults unless speculative
  wire dFaultEv = dDone && dRelPath && dHit && dProtDeny && !dSpec;
  wire dNoopEv = dDone && dRelPath &&
    ((dSpec && dHit && dProtDeny) || (dTouch && !dHit));
  // R13 every failure but a dropped speculative op interrupts
  wire faultAny = iMissEv || dMissEv || dFaultEv || isiEv;

  // R10 physical address, identity without relocation
  wire [31:0] iPhys = iRelPath ?
    physAddr(fetchAddr, iLo, iHi[HI_SIZE +: 3]) : fetchAddr;
  wire [31:0] dPhys = dRelPath ?
    physAddr(dataAddr, dLo, dHi[HI_SIZE +: 3]) : dataAddr;
  // R12 attributes pass only once access is allowed
  wire iAllow = iRelPath && iHit && !iProtDeny;
  wire dAllow = dRelPath && dHit && !dProtDeny;
  wire [3:0] iAttr = iAllow ? {iHi[HI_ENDIAN], iLo[LO_WT], iLo[LO_INH],
    iLo[LO_GRD]} : 4'h0;
  wire [3:0] dAttr = dAllow ? {dHi[HI_ENDIAN], dLo[LO_WT], dLo[LO_INH],
    dLo[LO_GRD]} : 4'h0;

  // Shadow refill from unified hits, round robin
  wire iFill = iFinish && uLk.hit;
  wire dFill = dFinish && uLk.hit;
  // A unified write may stale the shadows, so drop them
  wire [HI_W-1:0] newHi = {ehi_q[31:EHI_LSB], pwdata[CMD_TID +: 8]};

  tlc_buffer #(.DEPTH(SHADOW_DEPTH)) u_ishadow (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(iFill),
    .wrIdx(iPtr_q),
    .wrHi(uLk.hi),
    .wrLo(uLk.lo),
    .invalAll(wrEcmd),
    .lk(iLk)
  );

  tlc_buffer #(.DEPTH(SHADOW_DEPTH)) u_dshadow (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(dFill),
    .wrIdx(dPtr_q),
    .wrHi(uLk.hi),
    .wrLo(uLk.lo),
    .invalAll(wrEcmd),
    .lk(dLk)
  );

  tlc_buffer #(.DEPTH(UNI_DEPTH)) u_unified (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrEcmd),
    .wrIdx(pwdata[3:0]),
    .wrHi(newHi),
    .wrLo(elo_q),
    .invalAll(1'b0),
    .lk(uLk)
  );

  // Protection checks, one per side
  tlc_prot u_iprot (
    .userMode(userMode),
    .lo(iLo),
    .customAttr(iHi[HI_CUSTOM]),
    .trapEn(trap_q),
    .zoneField(zoneOf(zone_q, iLo[LO_ZONE_SELECTOR +: 4])),
    .kind(K_LOAD),
    .fetchDeny(iProtDeny),
    .dataDeny()
  );

  tlc_prot u_dprot (
    .userMode(userMode),
    .lo(dLo),
    .customAttr(dHi[HI_CUSTOM]),
    .trapEn(trap_q),
    .zoneField(zoneOf(zone_q, dLo[LO_ZONE_SELECTOR +: 4])),
    .kind(dataKind),
    .fetchDeny(),
    .dataDeny(dProtDeny)
  );

  // Fetch side sequencer
  always_comb begin
    iState_d = iState_q;
    iCnt_d = iCnt_q;
    unique case (iState_q)
      SIDE_IDLE: if (iUniReq) iState_d = iGrant ? SIDE_UNI : SIDE_WAIT;
      SIDE_WAIT: if (iGrant) iState_d = SIDE_UNI;
      SIDE_UNI: if (iFinish) iState_d = SIDE_IDLE;
      default: iState_d = SIDE_IDLE;
    endcase
    // R2 four extra cycles on an instruction shadow miss
    if (iGrant) begin
      iCnt_d = IMISS_CYCLES - 3'h1;
    end else if (iUseUni && !iFinish) begin
      iCnt_d = iCnt_q - 3'h1;
    end
  end

  // Data side sequencer
  always_comb begin
    dState_d = dState_q;
    dCnt_d = dCnt_q;
    unique case (dState_q)
      SIDE_IDLE: if (dUniReq) dState_d = dGrant ? SIDE_UNI : SIDE_WAIT;
      SIDE_WAIT: if (dGrant) dState_d = SIDE_UNI;
      SIDE_UNI: if (dFinish) dState_d = SIDE_IDLE;
      default: dState_d = SIDE_IDLE;
    endcase
    // R3 three extra cycles on a data shadow miss
    if (dGrant) begin
      dCnt_d = DMISS_CYCLES - 3'h1;
    end else if (dUseUni && !dFinish) begin
      dCnt_d = dCnt_q - 3'h1;
    end
  end

  // Control and status next values
  always_comb begin
    ctrl_d = wrCtrl ? pwdata[2:0] : ctrl_q;
    // R13 hardware drop of relocation beats a software write
    if (faultAny) begin
      ctrl_d[CTRL_IREL] = 1'b0;
      ctrl_d[CTRL_DREL] = 1'b0;
    end
    // Write one to clear; a new event wins
    stat_d = (wrStat ? stat_q & ~pwdata[3:0] : stat_q) |
      {isiEv, dFaultEv, dMissEv, iMissEv};
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iState_q <= SIDE_IDLE;
      dState_q <= SIDE_IDLE;
      iCnt_q <= 3'h0;
      dCnt_q <= 3'h0;
      iPtr_q <= 2'h0;
      dPtr_q <= 2'h0;
    end else begin
      iState_q <= iState_d;
      dState_q <= dState_d;
      iCnt_q <= iCnt_d;
      dCnt_q <= dCnt_d;
      iPtr_q <= iPtr_q + {1'b0, iFill};
      dPtr_q <= dPtr_q + {1'b0, dFill};
    end
  end

  // Registers seen by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      pid_q <= PID_RST;
      zone_q <= ZONE_RST;
      trap_q <= 1'b0;
      ehi_q <= ENTRY_RST;
      elo_q <= ENTRY_RST;
      stat_q <= STAT_RST;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      if (wrPid) pid_q <= pwdata[7:0];
      if (wrZone) zone_q <= pwdata;
      if (wrCfg) trap_q <= pwdata[CFG_TRAP];
      if (wrEhi) ehi_q <= pwdata;
      if (wrElo) elo_q <= pwdata;
      if (apbSetup) prdata_q <= rdMux;
    end
  end

  // Fetch results
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetchDone_q <= 1'b0;
      fetchPhys_q <= 32'h0;
      fetchAttr_q <= 4'h0;
      fetchMiss_q <= 1'b0;
      fetchDeny_q <= 1'b0;
      isi_q <= 1'b0;
    end else begin
      fetchDone_q <= iDone;
      fetchMiss_q <= iMissEv;
      isi_q <= isiEv;
      if (iDone) begin
        fetchPhys_q <= iPhys;
        fetchAttr_q <= iAttr;
        fetchDeny_q <= iDenyEv;
      end
    end
  end

  // Data results
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataDone_q <= 1'b0;
      dataPhys_q <= 32'h0;
      dataAttr_q <= 4'h0;
      dataMiss_q <= 1'b0;
      dataFault_q <= 1'b0;
      dataNoop_q <= 1'b0;
    end else begin
      dataDone_q <= dDone;
      dataMiss_q <= dMissEv;
      dataFault_q <= dFaultEv;
      dataNoop_q <= dNoopEv;
      if (dDone) begin
        dataPhys_q <= dPhys;
        dataAttr_q <= dAttr;
      end
    end
  end

  assign fetchDone = fetchDone_q;
  assign fetchPhys = fetchPhys_q;
  assign fetchAttr = fetchAttr_q;
  assign fetchMiss = fetchMiss_q;
  assign fetchDeny = fetchDeny_q;
  assign instrStorageFault = isi_q;
  assign dataDone = dataDone_q;
  assign dataPhys = dataPhys_q;
  assign dataAttr = dataAttr_q;
  assign dataMiss = dataMiss_q;
  assign dataStorageFault = dataFault_q;
  assign dataNoop = dataNoop_q;
endmodule

/* File: bench/tlc_mmu_assertions.sv */
// Port checker of the translation block
module tlc_mmu_assertions import tlc_pkg::*; (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic fetchReq, // Fetch request
  input wire logic fetchDone, // Fetch result
  input wire logic fetchMiss, // Fetch miss
  input wire logic [3:0] fetchAttr, // Fetch attrs
  input wire logic execValid, // Executes
  input wire logic execDeny, // Deny tag
  input wire logic instrStorageFault, // Exec fault
  input wire logic dataReq, // Data request
  input wire logic dataDone, // Data result
  input wire logic dataMiss, // Data miss
  input wire tlc_kind_t dataKind, // Access kind
  input wire logic dataStorageFault // Data fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Fault timing and pulse shape
  a_isi_exec: assert property (
    execValid && execDeny |=> instrStorageFault)
    else $error("exec fault missing");
  a_isi_cause: assert property (
    instrStorageFault |-> $past(execValid && execDeny))
    else $error("stray exec fault");
  a_fmiss_pulse: assert property (
    fetchMiss |-> fetchDone && fetchAttr == 4'h0)
    else $error("stray fetch miss");
  a_dmiss_kind: assert property (
    dataMiss |-> dataDone && dataKind != K_TOUCH)
    else $error("bad data miss");
  a_dsf_pulse: assert property (
    dataStorageFault |-> dataDone && !dataMiss)
    else $error("stray data fault");
  // Unified lookups cost the full penalty
  a_fmiss_late: assert property (
    fetchMiss |-> $past(fetchReq, 5))
    else $error("fetch miss too early");
  a_dmiss_late: assert property (
    dataMiss |-> $past(dataReq, 4))
    else $error("data miss too early");
  a_fetch_bound: assert property (
    $rose(fetchReq) |-> ##[1:12] fetchDone)
    else $error("fetch unanswered");
  a_data_bound: assert property (
    $rose(dataReq) |-> ##[1:12] dataDone)
    else $error("data unanswered");
  a_fdone_once: assert property (
    fetchDone |=> !fetchDone)
    else $error("fetch result repeated");
  c_fmiss: cover property (fetchMiss);
  c_dfault: cover property (dataStorageFault);
  c_touch: cover property (dataDone && dataKind == K_TOUCH);
endmodule

/* File: bench/tlc_pipe_model.sv */
// Pipeline unit presenting one lookup request
module tlc_pipe_model import tlc_pkg::*; (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic start, // Begin request
  input wire logic [31:0] ea, // Address
  input wire tlc_kind_t kd, // Kind
  input wire logic done, // Result pulse
  input wire logic [2:0] flg, // Result flags
  output logic req, // Held request
  output logic [31:0] addr, // Held address
  output tlc_kind_t kind, // Held kind
  output logic [7:0] lat, // Take to done
  output logic [2:0] seen // Flags at done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // Scramble released address so stale use shows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req <= 1'b0;
      addr <= 32'hA5A5A5A5;
      kind <= K_LOAD;
      cnt_q <= 8'h00;
    end else if (start) begin
      req <= 1'b1;
      addr <= ea;
      kind <= kd;
      cnt_q <= 8'h00;
    end else if (req && done) begin
      req <= 1'b0;
      addr <= ~addr;
      lat <= cnt_q;
      seen <= flg;
    end else if (req) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: bench/tlc_mmu_tb.sv */
// Self-checking bench of the translation block
module tlc_mmu_tb import tlc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FL = {5'h00, IMISS_CYCLES} + 8'h01;
  localparam logic [7:0] DL = {5'h00, DMISS_CYCLES} + 8'h01;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, fLat, dLat;
  logic [31:0] pwdata, prdata, fetchAddr, fetchPhys, dataAddr, dataPhys, ea;
  logic [3:0] fetchAttr, dataAttr;
  logic fetchReq, fetchDone, fetchMiss, fetchDeny, execValid, execDeny;
  logic instrStorageFault, dataReq, dataDone, dataMiss, dataStorageFault;
  logic dataNoop, fStart, dStart;
  logic [2:0] fSeen, dSeen;
  tlc_kind_t dataKind, dKd;
  int mismatches, cmp_count, cyc;
  tlc_mmu dut (.*);
  tlc_pipe_model fm (.clk(clk), .sys_rst(sys_rst), .start(fStart), .ea(ea),
    .kd(K_LOAD), .done(fetchDone), .flg({fetchMiss, fetchDeny, 1'b0}),
    .req(fetchReq), .addr(fetchAddr), .kind(), .lat(fLat), .seen(fSeen));
  tlc_pipe_model dm (.clk(clk), .sys_rst(sys_rst), .start(dStart), .ea(ea),
    .kd(dKd), .done(dataDone), .flg({dataMiss, dataStorageFault, dataNoop}),
    .req(dataReq), .addr(dataAddr), .kind(dataKind), .lat(dLat),
    .seen(dSeen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard above run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic ent(input logic [3:0] i, input logic [31:0] hi, lo,
      input logic [7:0] entry_process_tag);
    wr(OFS_EHI, hi);
    wr(OFS_ELO, lo);
    wr(OFS_ECMD, {16'h0000, entry_process_tag, 4'h0, i});
  endtask
  // One lookup: latency, flags, clean phys address
  task automatic go(input logic f, input logic [31:0] a, input tlc_kind_t k,
      input logic [7:0] el, input logic [31:0] ep, input logic [2:0] ef);
    ea <= a;
    dKd <= k;
    if (f) fStart <= 1'b1;
    else dStart <= 1'b1;
    @(posedge clk);
    fStart <= 1'b0;
    dStart <= 1'b0;
    if (f) wait (fetchReq);
    else wait (dataReq);
    if (f) wait (!fetchReq);
    else wait (!dataReq);
    @(posedge clk);
    chk({24'h0, f ? fLat : dLat}, {24'h0, el});
    chk({29'h0, f ? fSeen : dSeen}, {29'h0, ef});
    if (ef == 3'h0) chk(f ? fetchPhys : dataPhys, ep);
  endtask
  task s_fetch;
    wr(OFS_ZONE, 32'h55555555);
    // one entry per page, unused bits zero
    ent(4'h0, 32'h123450C0, 32'hABCDE300, 8'h00);
    wr(OFS_CTRL, 32'h2);
    go(1'b1, 32'h12345ABC, K_LOAD, FL, 32'hABCDEABC, 3'h0);
    go(1'b1, 32'h12345004, K_LOAD, 8'h01, 32'hABCDE004, 3'h0);
  endtask
  task s_store;
    ent(4'h1, 32'h00400040, 32'h00800000, 8'h00);
    wr(OFS_CTRL, 32'h5);
    go(1'b0, 32'h00400010, K_STORE, DL, 32'h0, 3'h2);
    rdc(OFS_CTRL, 32'h1);
    go(1'b0, 32'h00400010, K_STORE, 8'h01, 32'h00400010, 3'h0);
    wr(OFS_ZONE, 32'hD5555555);
    wr(OFS_CTRL, 32'h5);
    go(1'b0, 32'h00400014, K_STORE, 8'h01, 32'h00800014, 3'h0);
    wr(OFS_ZONE, 32'h15555555);
    go(1'b0, 32'h00400018, K_LOAD, 8'h01, 32'h0, 3'h2);
    wr(OFS_CTRL, 32'h4);
    go(1'b0, 32'h00400018, K_LOAD, 8'h01, 32'h00800018, 3'h0);
  endtask
  task s_pid;
    wr(OFS_ZONE, 32'h55555555);
    wr(OFS_PID, 32'h0);
    ent(4'h2, 32'h00800050, 32'h00C00300, 8'h07);
    wr(OFS_CTRL, 32'h4);
    go(1'b0, 32'h00800020, K_TOUCH, DL, 32'h0, 3'h1);
    go(1'b0, 32'h00800020, K_LOAD, DL, 32'h0, 3'h4);
    rdc(OFS_STAT, 32'h6);
    wr(OFS_PID, 32'h7);
    wr(OFS_CTRL, 32'h4);
    go(1'b0, 32'h00800024, K_LOAD, DL, 32'h00C00024, 3'h0);
    wr(OFS_CFG, 32'h1);
    go(1'b0, 32'h00800028, K_ZERO, 8'h01, 32'h0, 3'h2);
  endtask
  task s_exec;
    wr(OFS_CTRL, 32'h2);
    go(1'b1, 32'h00400000, K_LOAD, FL, 32'h0, 3'h2);
    execValid <= 1'b1;
    execDeny <= fetchDeny;
    @(posedge clk);
    execValid <= 1'b0;
    @(negedge clk);
    chk({31'h0, instrStorageFault}, 32'h1);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, execValid, execDeny} = '0;
    {fStart, dStart, ea, mismatches, cmp_count, cyc} = '0;
    dKd = K_LOAD;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFS_CTRL, 32'h0);
    rdc(8'h20, 32'h0);
    chk({31'h0, perr}, 32'h1);
    s_fetch;
    s_store;
    s_pid;
    s_exec;
    conclude;
  end
endmodule
bind tlc_mmu tlc_mmu_assertions chk_i (.*);
